// file: design/octo_defines.vh
// Register offsets, source codes, reset values and timer width of the contact override block.
`ifndef OCTO_DEFINES_VH
`define OCTO_DEFINES_VH
`define OCTO_NCONTACT        8
`define OCTO_ADR_MAINT       4'h0
`define OCTO_ADR_DISARM      4'h1
`define OCTO_ADR_GFORCE      4'h2
`define OCTO_ADR_SFORCE_EN   4'h3
`define OCTO_ADR_SFORCE_VAL  4'h4
`define OCTO_ADR_DTIME       4'h5
`define OCTO_ADR_FTIME       4'h6
`define OCTO_ADR_STATUS      4'h7
`define OCTO_ADR_OUTS        4'h8
`define OCTO_ADR_SERVICE     4'h9
`define OCTO_SRC_MANUAL      2'h0
`define OCTO_SRC_COMM        2'h1
`define OCTO_SRC_INPUT       2'h2
`define OCTO_TIMER_W         32
`define OCTO_TIMER_RESET     32'h0000_0000
`define OCTO_PROTECTED_RESET 8'h03
`define OCTO_REBOOT_KEY      16'hA5C3
`endif

// file: design/octo_override.v
// Service override of relay output contacts: maintenance selection, disarm and force.
//
// Functional notes
// [RULE1] Maintenance state is kept in nonvolatile storage across power loss.
// [RULE2] Maintenance activation from panel, communication or input; manual only locally.
// [RULE3] Source change refused while the selected source asserts activation.
// [RULE4] Complementary maintenance active and inactive flags are provided.
// [RULE5] Whole contact groups can be disarmed; disarmed contacts never switch.
// [RULE6] Zone interlocking and supervision contacts are never disarmed.
// [RULE7] Timed disarm holds only while its timer runs.
// [RULE8] Permanent disarm holds until removed.
// [RULE9] Disarm needs unlatched, no hold-off, control enabled and command applied.
// [RULE10] Disarm of a latched contact waits for latch reset.
// [RULE11] Disarm waits for the hold-off timer to expire.
// [RULE12] Timed force holds only while its timer runs.
// [RULE13] Permanent force holds until removed.
// [RULE14] Group force takes precedence over single-contact force.
// [RULE15] Force commands are ignored for disarmed contacts.
// [RULE16] Force applies only when not disarmed and the command is applied.
// [RULE17] A reboot can be requested by service command.
// [RULE18] Healthy indicator steady green only after boot with protection running.
// [RULE19] Disarm and force timeouts come from down counters on the device clock.
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "octo_defines.vh"
module octo_override (
  input  wire        CLOCK,
  input  wire        RESET,
  input  wire        CLOCK_ENABLE,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [3:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output wire        WB_ACK_O,
  input  wire        WB_LOCAL_I,
  input  wire        NV_MAINT_VALID,
  input  wire        NV_MAINT_STATE,
  output reg         NV_MAINT_WRITE,
  output reg         NV_MAINT_DATA,
  input  wire        MAINT_COMM_CMD,
  input  wire        MAINT_INPUT,
  input  wire [7:0]  CONTACT_REQUEST,
  input  wire [7:0]  CONTACT_LATCHED,
  input  wire [7:0]  CONTACT_HOLDOFF,
  input  wire        BOOT_DONE,
  input  wire        PROTECTION_RUNNING,
  output reg  [7:0]  CONTACT_DRIVE,
  output wire        MAINT_ACTIVE,
  output wire        MAINT_INACTIVE,
  output reg         REBOOT_REQUEST,
  output reg         HEALTHY_GREEN
);

  localparam ST_LOAD = 2'b01;
  localparam ST_RUN  = 2'b10;

  reg  [1:0]  state;
  reg         maint_manual;
  reg         maint_active;
  reg  [1:0]  maint_src;
  reg         src_refused;
  reg  [7:0]  protected_mask;
  reg  [7:0]  disarm_group;
  reg         disarm_ctrl;
  reg         disarm_cmd;
  reg         disarm_timed;
  reg  [7:0]  gforce_group;
  reg  [7:0]  gforce_value;
  reg  [7:0]  sforce_en;
  reg  [7:0]  sforce_value;
  reg         force_cmd;
  reg         force_timed;
  reg  [31:0] disarm_time;
  reg  [31:0] force_time;
  reg  [31:0] disarm_count;
  reg  [31:0] force_count;
  reg         ack;
  reg  [7:0]  disarmed;
  reg         next_maint;
  reg         src_signal;
  reg  [7:0]  next_drive;

  wire        access  = WB_CYC_I & WB_STB_I & ~ack;
  wire        wr      = access & WB_WE_I & WB_SEL_I[0];
  wire        wr_hi   = access & WB_WE_I & WB_SEL_I[1];
  wire        disarm_live = disarm_cmd & (~disarm_timed | (disarm_count != 32'h0000_0000));
  wire        force_live  = force_cmd & (~force_timed | (force_count != 32'h0000_0000));
  wire        rd_maint;

  assign WB_ACK_O       = ack;
  assign MAINT_ACTIVE   = maint_active;   // [RULE4]
  assign MAINT_INACTIVE = ~maint_active;  // [RULE4]
  assign rd_maint       = maint_active;

  // Level of the activation signal from whichever source is now selected.
  always @* begin
    case (maint_src)
      `OCTO_SRC_COMM:  src_signal = MAINT_COMM_CMD;
      `OCTO_SRC_INPUT: src_signal = MAINT_INPUT;
      default:         src_signal = maint_manual;
    endcase
  end

  // Maintenance state follows the selected source only.
  always @* begin
    case (maint_src)
      `OCTO_SRC_COMM:  next_maint = MAINT_COMM_CMD;  // [RULE2]
      `OCTO_SRC_INPUT: next_maint = MAINT_INPUT;     // [RULE2]
      default:         next_maint = maint_manual;    // [RULE2]
    endcase
  end

  // Latched or holding contacts stay armed until they release on their own.
  always @* begin
    disarmed = disarm_group & ~protected_mask                  // [RULE5] [RULE6]
             & ~CONTACT_LATCHED & ~CONTACT_HOLDOFF             // [RULE9] [RULE10] [RULE11]
             & {8{disarm_ctrl & disarm_live}};                 // [RULE7] [RULE8] [RULE9]
  end

  always @* begin
    next_drive = CONTACT_REQUEST;
    if (force_live) begin
      next_drive = (next_drive & ~sforce_en) | (sforce_value & sforce_en);       // [RULE16]
      next_drive = (next_drive & ~gforce_group) | (gforce_value & gforce_group); // [RULE14]
    end
    next_drive = next_drive & ~disarmed;                                         // [RULE15] [RULE5]
  end

  always @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state          <= ST_LOAD;
      maint_manual   <= 1'b0;
      maint_active   <= 1'b0;
      maint_src      <= `OCTO_SRC_MANUAL;
      src_refused    <= 1'b0;
      protected_mask <= `OCTO_PROTECTED_RESET;
      disarm_group   <= 8'h00;
      disarm_ctrl    <= 1'b0;
      disarm_cmd     <= 1'b0;
      disarm_timed   <= 1'b0;
      gforce_group   <= 8'h00;
      gforce_value   <= 8'h00;
      sforce_en      <= 8'h00;
      sforce_value   <= 8'h00;
      force_cmd      <= 1'b0;
      force_timed    <= 1'b0;
      disarm_time    <= `OCTO_TIMER_RESET;
      force_time     <= `OCTO_TIMER_RESET;
      disarm_count   <= `OCTO_TIMER_RESET;
      force_count    <= `OCTO_TIMER_RESET;
      ack            <= 1'b0;
      WB_DAT_O       <= 32'h0000_0000;
      NV_MAINT_WRITE <= 1'b0;
      NV_MAINT_DATA  <= 1'b0;
      CONTACT_DRIVE  <= 8'h00;
      REBOOT_REQUEST <= 1'b0;
      HEALTHY_GREEN  <= 1'b0;
    end else if (CLOCK_ENABLE) begin
      ack            <= access;
      NV_MAINT_WRITE <= 1'b0;
      REBOOT_REQUEST <= 1'b0;
      HEALTHY_GREEN  <= (state == ST_RUN) & BOOT_DONE & PROTECTION_RUNNING;  // [RULE18]
      CONTACT_DRIVE  <= next_drive;
      case (state)
        ST_LOAD: begin
          // Restore the stored selection once the storage reports valid data.
          if (NV_MAINT_VALID) begin
            maint_manual <= NV_MAINT_STATE;  // [RULE1]
            maint_active <= NV_MAINT_STATE;  // [RULE1]
            state        <= ST_RUN;
          end
        end
        ST_RUN: begin
          maint_active <= next_maint;
          if (next_maint != maint_active) begin
            NV_MAINT_WRITE <= 1'b1;        // [RULE1]
            NV_MAINT_DATA  <= next_maint;  // [RULE1]
          end
        end
        default: state <= ST_LOAD;
      endcase
      // Timers reload on a command write and count down to zero.
      if (disarm_count != 32'h0000_0000)
        disarm_count <= disarm_count - 32'h0000_0001;  // [RULE19] [RULE7]
      if (force_count != 32'h0000_0000)
        force_count <= force_count - 32'h0000_0001;    // [RULE19] [RULE12]
      if (disarm_cmd & disarm_timed & (disarm_count == 32'h0000_0000))
        disarm_cmd <= 1'b0;  // [RULE7]
      if (force_cmd & force_timed & (force_count == 32'h0000_0000))
        force_cmd <= 1'b0;   // [RULE12]
      if (wr) begin
        case (WB_ADR_I)
          `OCTO_ADR_MAINT: begin
            // Manual entry is honoured from the local panel only.
            if (WB_LOCAL_I)
              maint_manual <= WB_DAT_I[0];  // [RULE2]
            if (WB_DAT_I[3:2] != maint_src) begin
              if (src_signal)
                src_refused <= 1'b1;         // [RULE3]
              else begin
                maint_src   <= WB_DAT_I[3:2];
                src_refused <= 1'b0;
              end
            end
          end
          `OCTO_ADR_DISARM: begin
            disarm_group <= WB_DAT_I[7:0];
            if (wr_hi) begin
              disarm_ctrl  <= WB_DAT_I[8];
              disarm_cmd   <= WB_DAT_I[9];   // [RULE8]
              disarm_timed <= WB_DAT_I[10];
              disarm_count <= WB_DAT_I[9] ? disarm_time : 32'h0000_0000;
            end
          end
          `OCTO_ADR_GFORCE: begin
            gforce_group <= WB_DAT_I[7:0];
            if (wr_hi)
              gforce_value <= WB_DAT_I[15:8];
            force_cmd   <= WB_DAT_I[16];     // [RULE13]
            force_timed <= WB_DAT_I[17];
            force_count <= WB_DAT_I[16] ? force_time : 32'h0000_0000;
          end
          `OCTO_ADR_SFORCE_EN: sforce_en <= WB_DAT_I[7:0];
          `OCTO_ADR_SFORCE_VAL: sforce_value <= WB_DAT_I[7:0];
          `OCTO_ADR_DTIME: disarm_time <= WB_DAT_I;
          `OCTO_ADR_FTIME: force_time <= WB_DAT_I;
          `OCTO_ADR_SERVICE: begin
            if (wr_hi && WB_DAT_I[15:0] == `OCTO_REBOOT_KEY)
              REBOOT_REQUEST <= 1'b1;        // [RULE17]
            protected_mask <= protected_mask;
          end
          default: ;
        endcase
      end
      if (access) begin
        case (WB_ADR_I)
          `OCTO_ADR_MAINT:  WB_DAT_O <= {27'h000_0000, src_refused, maint_src, rd_maint,
                                         maint_manual};
          `OCTO_ADR_DISARM: WB_DAT_O <= {21'h00_0000, disarm_timed, disarm_cmd, disarm_ctrl,
                                         disarm_group};
          `OCTO_ADR_GFORCE: WB_DAT_O <= {14'h0000, force_timed, force_cmd, gforce_value,
                                         gforce_group};
          `OCTO_ADR_SFORCE_EN:  WB_DAT_O <= {24'h00_0000, sforce_en};
          `OCTO_ADR_SFORCE_VAL: WB_DAT_O <= {24'h00_0000, sforce_value};
          `OCTO_ADR_DTIME:  WB_DAT_O <= disarm_count;
          `OCTO_ADR_FTIME:  WB_DAT_O <= force_count;
          `OCTO_ADR_STATUS: WB_DAT_O <= {16'h0000, protected_mask, disarmed};
          `OCTO_ADR_OUTS:   WB_DAT_O <= {24'h00_0000, CONTACT_DRIVE};
          default:          WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // octo_override
`default_nettype wire

// file: dv/octo_override_chk.sv
// Port timing checker of the contact override block.
`timescale 1ns/10ps
`default_nettype none
module octo_override_chk (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CLOCK_ENABLE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic NV_MAINT_WRITE,
  input wire logic MAINT_ACTIVE,
  input wire logic MAINT_INACTIVE,
  input wire logic REBOOT_REQUEST,
  input wire logic BOOT_DONE,
  input wire logic PROTECTION_RUNNING,
  input wire logic HEALTHY_GREEN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  ack_late_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CLOCK_ENABLE |=> WB_ACK_O)
    else $error("ack late");
  ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  maint_pair_a: assert property (MAINT_ACTIVE != MAINT_INACTIVE)
    else $error("maintenance flags agree");
  nv_pulse_a: assert property (NV_MAINT_WRITE |=> !NV_MAINT_WRITE)
    else $error("store write too long");
  reboot_pulse_a: assert property (REBOOT_REQUEST |=> !REBOOT_REQUEST)
    else $error("reboot too long");
  green_cause_a: assert property (HEALTHY_GREEN |-> $past(BOOT_DONE && PROTECTION_RUNNING))
    else $error("green too early");
  green_rise_a: assert property ((BOOT_DONE && PROTECTION_RUNNING) [*2] |-> HEALTHY_GREEN)
    else $error("green missing");
endmodule // octo_override_chk
bind octo_override octo_override_chk octo_override_chk_inst (.CLOCK, .RESET, .CLOCK_ENABLE,
  .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .NV_MAINT_WRITE, .MAINT_ACTIVE, .MAINT_INACTIVE,
  .REBOOT_REQUEST, .BOOT_DONE, .PROTECTION_RUNNING, .HEALTHY_GREEN);
`default_nettype wire

// file: dv/octo_gear_model.sv
// Switchgear seen by the contacts: each position follows its contact one cycle late.
`timescale 1ns/10ps
`default_nettype none
module octo_gear_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] drive,
  output var  logic [7:0] position
);
  always_ff @(posedge clk or posedge rst) position <= rst ? 8'h00 : drive;
endmodule // octo_gear_model
`default_nettype wire

// file: dv/octo_override_tb.sv
// Self-checking bench of the contact override block.
`timescale 1ns/10ps
`default_nettype none
`include "octo_defines.vh"
module octo_override_tb;
  typedef struct {logic [15:0] d; logic [19:0] g; logic [7:0] se, sv, rq, la, ho, ex;} octo_row_t;
  logic        CLOCK = 0, RESET = 1, cyc = 0, stb = 0, we = 0, loc = 0, nvv = 0, comm = 0;
  logic        boot = 0, prot = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0000_0000, q;
  logic [7:0]  rq = 8'h00, la = 8'h00, ho = 8'h00, pos;
  wire  [31:0] dat_o;
  wire  [7:0]  drive;
  wire         ack, nvw, nvd, mact, minact, rbt, green;
  int          err_count = 0, checks = 0, i, n0, nv_n = 0, rb_n = 0;
  octo_row_t   rows [8] = '{
    '{16'h0000, 20'h0_0000, 8'h00, 8'h00, 8'hA5, 8'h00, 8'h00, 8'hA5},
    '{16'h03F0, 20'h0_0000, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h0F},
    '{16'h03FF, 20'h0_0000, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h03},
    '{16'h02F0, 20'h0_0000, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF},
    '{16'h03F0, 20'h0_0000, 8'h00, 8'h00, 8'hFF, 8'h10, 8'h20, 8'h3F},
    '{16'h0000, 20'h0_0000, 8'h0F, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00},
    '{16'h0000, 20'h1_0203, 8'h0F, 8'h05, 8'h00, 8'h00, 8'h00, 8'h06},
    '{16'h03F0, 20'h1_F0F0, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h0F}};
  octo_override octo_override_inst (.CLOCK(CLOCK), .RESET(RESET), .CLOCK_ENABLE(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .WB_LOCAL_I(loc),
    .NV_MAINT_VALID(nvv), .NV_MAINT_STATE(1'b1), .NV_MAINT_WRITE(nvw), .NV_MAINT_DATA(nvd),
    .MAINT_COMM_CMD(comm), .MAINT_INPUT(1'b0), .CONTACT_REQUEST(rq), .CONTACT_LATCHED(la),
    .CONTACT_HOLDOFF(ho), .BOOT_DONE(boot), .PROTECTION_RUNNING(prot), .CONTACT_DRIVE(drive),
    .MAINT_ACTIVE(mact), .MAINT_INACTIVE(minact), .REBOOT_REQUEST(rbt), .HEALTHY_GREEN(green));
  octo_gear_model octo_gear_model_inst (.clk(CLOCK), .rst(RESET), .drive(drive), .position(pos));
  initial forever #10 CLOCK = ~CLOCK;
  // Pulses are counted so a check later on cannot miss a one-cycle event.
  always @(posedge CLOCK) begin
    nv_n <= nv_n + nvw;
    rb_n <= rb_n + rbt;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLOCK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // Ack and read data are taken at the rising edge, before that edge updates them.
    do begin
      @(posedge CLOCK);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      err_count++;
      end_sim;
    end
  endtask
  initial begin
    @(negedge CLOCK);
    chk({minact, drive}, 32'h0000_0100);
    repeat (2) @(posedge CLOCK);
    RESET <= 1'b0;
    repeat (3) @(posedge CLOCK);
    nvv <= 1'b1;
    chk(mact, 1'b0);
    repeat (3) @(negedge CLOCK);
    chk(mact, 1'b1);
    for (i = 0; i < 8; i++) begin
      @(posedge CLOCK);
      rq <= rows[i].rq;
      la <= rows[i].la;
      ho <= rows[i].ho;
      wb(1'b1, `OCTO_ADR_DISARM, 32'(rows[i].d));
      wb(1'b1, `OCTO_ADR_GFORCE, 32'(rows[i].g));
      wb(1'b1, `OCTO_ADR_SFORCE_EN, 32'(rows[i].se));
      wb(1'b1, `OCTO_ADR_SFORCE_VAL, 32'(rows[i].sv));
      repeat (3) @(negedge CLOCK);
      chk(drive, rows[i].ex);
      chk(pos, rows[i].ex);
    end
    wb(1'b1, `OCTO_ADR_GFORCE, 32'h0000_0000);
    wb(1'b1, `OCTO_ADR_DISARM, 32'h0000_0000);
    wb(1'b1, `OCTO_ADR_DTIME, 32'h0000_0008);
    rq <= 8'hFF;
    wb(1'b1, `OCTO_ADR_DISARM, 32'h0000_07F0);
    repeat (2) @(negedge CLOCK);
    chk(drive, 8'h0F);
    repeat (12) @(negedge CLOCK);
    chk(drive, 8'hFF);
    wb(1'b1, `OCTO_ADR_DISARM, 32'h0000_0000);
    wb(1'b1, `OCTO_ADR_FTIME, 32'h0000_0008);
    wb(1'b1, `OCTO_ADR_GFORCE, 32'h0003_00FF);
    repeat (2) @(negedge CLOCK);
    chk(drive, 8'h00);
    repeat (12) @(negedge CLOCK);
    chk(drive, 8'hFF);
    wb(1'b1, `OCTO_ADR_MAINT, 32'h0000_0000);
    chk(mact, 1'b1);
    loc <= 1'b1;
    n0 = nv_n;
    wb(1'b1, `OCTO_ADR_MAINT, 32'h0000_0000);
    repeat (2) @(negedge CLOCK);
    chk({minact, (nv_n > n0)}, 2'b11);
    comm <= 1'b1;
    wb(1'b1, `OCTO_ADR_MAINT, 32'h0000_0004);
    wb(1'b1, `OCTO_ADR_MAINT, 32'h0000_0008);
    wb(1'b0, `OCTO_ADR_MAINT, 32'h0000_0000);
    chk(q[4:1], 4'b1011);
    n0 = rb_n;
    wb(1'b1, `OCTO_ADR_SERVICE, {16'h0000, `OCTO_REBOOT_KEY});
    boot <= 1'b1;
    repeat (3) @(negedge CLOCK);
    chk({rb_n - n0, green}, 2'b10);
    wb(1'b0, 4'hF, 32'h0000_0000);
    prot <= 1'b1;
    chk(q, 32'h0000_0000);
    repeat (3) @(negedge CLOCK);
    chk(green, 1'b1);
    end_sim;
  end
endmodule // octo_override_tb
`default_nettype wire
